// File: hdl/gmes_params.svh
// Purpose: Named constants for the guest memory encryption select block.
// Assumes: 64-bit page table entries and addresses, 4KB pages.
// Notes: Included by its bare name.
`ifndef GMES_PARAMS_SVH
`define GMES_PARAMS_SVH
`define GMES_FLUSH_REG_ADDR 32'hc001011e
`define GMES_VA_HI 63
`define GMES_VA_LO 12
`define GMES_KEY_HI 3
`define GMES_KEY_LO 0
`define GMES_HOST_KEY 4'h0
`define GMES_CAP_FLUSH_BIT 2
`define GMES_CBIT_POS_DEFAULT 6'h2f
`define GMES_PAGE_OFFSET_ZERO 12'h000
`define GMES_ADDR_ZERO 64'h0000000000000000
`endif

// File: hdl/gmes_pkg.sv
// Purpose: Types shared by the guest memory encryption select block.
// Assumes: Nothing beyond the constants header.
// Notes: Access kinds and flush states.
package gmes_pkg;
   typedef enum logic [1:0] {
      GMES_ACC_FETCH,
      GMES_ACC_GUEST_TABLE,
      GMES_ACC_NESTED_TABLE,
      GMES_ACC_DATA
   } gmes_access_t;
   typedef enum logic [1:0] {
      GMES_FL_IDLE,
      GMES_FL_XLATE,
      GMES_FL_CACHE
   } gmes_flush_state_t;
endpackage : gmes_pkg

// File: hdl/gmes_cbit_strip.sv
// Purpose: Clears the encryption select bit from an address and reports its value.
// Assumes: Bit position below 64.
// Notes: Purely combinational.
`timescale 1ns/10ps
`include "gmes_params.svh"
module gmes_cbit_strip (
   // Address in
   input wire logic [63:0] addr_in,
   input wire logic [5:0] cbit_pos,
   input wire logic cbit_is_addr,
   // Address out
   output logic [63:0] addr_out,
   output logic cbit_val
);
   logic [63:0] mask;
   always_comb begin
      mask = `GMES_ADDR_ZERO;
      mask[cbit_pos] = 1'b1;
      cbit_val = addr_in[cbit_pos];
      addr_out = cbit_is_addr ? (addr_in & ~mask) : addr_in;
   end
endmodule : gmes_cbit_strip

// File: hdl/gmes_select.sv
// Purpose: Per-access encryption and key selection plus the guest page flush register.
// Assumes: Core supplies mode bits and page table markings in the access cycle.
// Notes: Results registered one cycle after a valid access.
//
// Summary of operation
// - Fetches and guest table walks always guest-private.
// - Guest data privacy from guest table bit.
// - Report select bit position; one shared position.
// - Clear select bit before nested translation.
// - Reattach select value to final address on data.
// - Guest address width shrinks one bit.
// - No coherency across encryption settings enforced.
// - Global enable off: none; host: host key.
// - Non-encrypted guest, nested tables: host key.
// - Guest encryption needs guest mode and enable.
// - Guest choice only in long or extended paging.
// - Nested walk: nested tables host key.
// - Shared data: host key if nested marks.
// - Guest marking wins over nested marking.
// - Capability bit advertises page flush register.
// - Flush write-backs one 4KB page per key.
// - Flush register: address high, key low.
// - Flush address goes through host tables.
// - Flush hits lines tagged with guest key.
// - Flush touches only guest-private lines.
`timescale 1ns/10ps
`include "gmes_params.svh"
module gmes_select (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Mode inputs
   input wire logic global_encryption_enable,
   input wire logic guest_mode,
   input wire logic guest_encryption_enable,
   input wire logic guest_long_or_ext_paging,
   input wire logic cbit_is_addr,
   // Access request
   input wire logic acc_valid,
   input wire gmes_pkg::gmes_access_t acc_kind,
   input wire logic [63:0] acc_addr,
   input wire logic host_table_cbit,
   input wire logic guest_table_cbit,
   input wire logic nested_table_cbit,
   input wire logic [3:0] guest_key_index,
   // Nested translation
   input wire logic [63:0] nested_spa,
   // Register write port
   input wire logic reg_wr,
   input wire logic [31:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   // Host translation and cache handshake
   input wire logic xlate_done,
   input wire logic [63:0] xlate_phys,
   input wire logic cache_done,
   // Access result
   output logic res_valid,
   output logic res_encrypt,
   output logic res_guest_key,
   output logic [3:0] res_key_index,
   output logic [63:0] res_nested_gpa,
   output logic [63:0] res_spa,
   // Flush outputs
   output logic xlate_req,
   output logic [63:0] xlate_vaddr,
   output logic cache_flush_req,
   output logic [63:0] cache_flush_addr,
   output logic [3:0] cache_flush_key,
   output logic cache_flush_private_only,
   output logic core_stall,
   // Capabilities
   output logic [5:0] cap_cbit_pos,
   output logic [31:0] cap_features
);
   logic [63:0] stripped;
   logic gpa_cbit;
   logic guest_enc_active;
   logic enc_c;
   logic gkey_c;
   logic res_valid_r, res_valid_nxt;
   logic res_encrypt_r, res_encrypt_nxt;
   logic res_guest_key_r, res_guest_key_nxt;
   logic [3:0] res_key_r, res_key_nxt;
   logic [63:0] res_gpa_r, res_gpa_nxt;
   logic [63:0] res_spa_r, res_spa_nxt;
   logic [63:0] spa_c;
   gmes_pkg::gmes_flush_state_t fl_r, fl_nxt;
   logic [63:0] fl_va_r, fl_va_nxt;
   logic [63:0] fl_pa_r, fl_pa_nxt;
   logic [3:0] fl_key_r, fl_key_nxt;
   logic [5:0] cap_pos_r;
   logic [31:0] cap_feat_r;
   logic xlate_req_r, xlate_req_nxt;
   logic cache_req_r, cache_req_nxt;
   logic stall_r, stall_nxt;
   logic private_only_r;

   // The same position serves guest and host tables.
   gmes_cbit_strip u_strip (
      .addr_in(acc_addr),
      .cbit_pos(cap_pos_r),
      .cbit_is_addr(cbit_is_addr),
      .addr_out(stripped),
      .cbit_val(gpa_cbit)
   );

   assign guest_enc_active = guest_mode & guest_encryption_enable & global_encryption_enable;

   // Encryption decision; caches are not kept coherent across settings.
   always_comb begin
      enc_c = 1'b0;
      gkey_c = 1'b0;
      if (!global_encryption_enable) begin
         enc_c = 1'b0;
      end else if (!guest_mode) begin
         enc_c = host_table_cbit;
      end else if (!guest_enc_active) begin
         enc_c = nested_table_cbit;
      end else begin
         case (acc_kind)
            gmes_pkg::GMES_ACC_FETCH, gmes_pkg::GMES_ACC_GUEST_TABLE: begin
               enc_c = 1'b1;
               gkey_c = 1'b1;
            end
            gmes_pkg::GMES_ACC_NESTED_TABLE: begin
               enc_c = nested_table_cbit;
            end
            default: begin
               if (!guest_long_or_ext_paging || guest_table_cbit) begin
                  enc_c = 1'b1;
                  gkey_c = 1'b1;
               end else begin
                  enc_c = nested_table_cbit;
               end
            end
         endcase
      end
   end

   // Final system address carries the guest select value on data.
   always_comb begin
      spa_c = nested_spa;
      if (guest_enc_active && cbit_is_addr && acc_kind == gmes_pkg::GMES_ACC_DATA) begin
         spa_c[cap_pos_r] = gpa_cbit;
      end
   end

   always_comb begin
      res_valid_nxt = acc_valid & ~stall_r;
      res_encrypt_nxt = res_encrypt_r;
      res_guest_key_nxt = res_guest_key_r;
      res_key_nxt = res_key_r;
      res_gpa_nxt = res_gpa_r;
      res_spa_nxt = res_spa_r;
      if (acc_valid && !stall_r) begin
         res_encrypt_nxt = enc_c;
         res_guest_key_nxt = gkey_c;
         res_key_nxt = gkey_c ? guest_key_index : `GMES_HOST_KEY;
         res_gpa_nxt = (guest_mode && guest_long_or_ext_paging) ? stripped : acc_addr;
         res_spa_nxt = spa_c;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         res_valid_r <= 1'b0;
         res_encrypt_r <= 1'b0;
         res_guest_key_r <= 1'b0;
         res_key_r <= `GMES_HOST_KEY;
         res_gpa_r <= `GMES_ADDR_ZERO;
         res_spa_r <= `GMES_ADDR_ZERO;
      end else begin
         res_valid_r <= res_valid_nxt;
         res_encrypt_r <= res_encrypt_nxt;
         res_guest_key_r <= res_guest_key_nxt;
         res_key_r <= res_key_nxt;
         res_gpa_r <= res_gpa_nxt;
         res_spa_r <= res_spa_nxt;
      end
   end

   // Page flush sequencer.
   always_comb begin
      fl_nxt = fl_r;
      fl_va_nxt = fl_va_r;
      fl_pa_nxt = fl_pa_r;
      fl_key_nxt = fl_key_r;
      case (fl_r)
         gmes_pkg::GMES_FL_IDLE: begin
            if (reg_wr && reg_addr == `GMES_FLUSH_REG_ADDR) begin
               fl_va_nxt = {reg_wdata[`GMES_VA_HI:`GMES_VA_LO], `GMES_PAGE_OFFSET_ZERO};
               fl_key_nxt = reg_wdata[`GMES_KEY_HI:`GMES_KEY_LO];
               fl_nxt = gmes_pkg::GMES_FL_XLATE;
            end
         end
         gmes_pkg::GMES_FL_XLATE: begin
            if (xlate_done) begin
               fl_pa_nxt = {xlate_phys[`GMES_VA_HI:`GMES_VA_LO], `GMES_PAGE_OFFSET_ZERO};
               fl_nxt = gmes_pkg::GMES_FL_CACHE;
            end
         end
         default: begin
            if (cache_done) begin
               fl_nxt = gmes_pkg::GMES_FL_IDLE;
            end
         end
      endcase
      // Request and stall outputs are registered copies of the next state.
      xlate_req_nxt = (fl_nxt == gmes_pkg::GMES_FL_XLATE);
      cache_req_nxt = (fl_nxt == gmes_pkg::GMES_FL_CACHE);
      stall_nxt = (fl_nxt != gmes_pkg::GMES_FL_IDLE);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fl_r <= gmes_pkg::GMES_FL_IDLE;
         fl_va_r <= `GMES_ADDR_ZERO;
         fl_pa_r <= `GMES_ADDR_ZERO;
         fl_key_r <= `GMES_HOST_KEY;
         cap_pos_r <= `GMES_CBIT_POS_DEFAULT;
         cap_feat_r <= 32'h00000000;
         xlate_req_r <= 1'b0;
         cache_req_r <= 1'b0;
         stall_r <= 1'b0;
         private_only_r <= 1'b1;
      end else begin
         fl_r <= fl_nxt;
         fl_va_r <= fl_va_nxt;
         fl_pa_r <= fl_pa_nxt;
         fl_key_r <= fl_key_nxt;
         cap_pos_r <= `GMES_CBIT_POS_DEFAULT;
         cap_feat_r <= 32'h00000001 << `GMES_CAP_FLUSH_BIT;
         xlate_req_r <= xlate_req_nxt;
         cache_req_r <= cache_req_nxt;
         stall_r <= stall_nxt;
         private_only_r <= 1'b1;
      end
   end

   assign res_valid = res_valid_r;
   assign res_encrypt = res_encrypt_r;
   assign res_guest_key = res_guest_key_r;
   assign res_key_index = res_key_r;
   assign res_nested_gpa = res_gpa_r;
   assign res_spa = res_spa_r;
   assign xlate_req = xlate_req_r;
   assign xlate_vaddr = fl_va_r;
   assign cache_flush_req = cache_req_r;
   assign cache_flush_addr = fl_pa_r;
   assign cache_flush_key = fl_key_r;
   assign cache_flush_private_only = private_only_r;
   assign core_stall = stall_r;
   assign cap_cbit_pos = cap_pos_r;
   assign cap_features = cap_feat_r;

   property p_fetch_private;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && guest_enc_active && acc_kind == gmes_pkg::GMES_ACC_FETCH)
         |=> (res_encrypt && res_guest_key);
   endproperty
   a_fetch_private: assert property (p_fetch_private) else $error("fetch not private");

   property p_off_none;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && !global_encryption_enable) |=> !res_encrypt;
   endproperty
   a_off_none: assert property (p_off_none) else $error("encrypt while disabled");

   property p_guest_wins;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && guest_enc_active && acc_kind == gmes_pkg::GMES_ACC_DATA
         && guest_table_cbit) |=> (res_guest_key && res_key_index == $past(guest_key_index));
   endproperty
   a_guest_wins: assert property (p_guest_wins) else $error("guest marking lost");

   property p_shared_host;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && guest_enc_active && acc_kind == gmes_pkg::GMES_ACC_DATA
         && guest_long_or_ext_paging && !guest_table_cbit)
         |=> (!res_guest_key && res_encrypt == $past(nested_table_cbit));
   endproperty
   a_shared_host: assert property (p_shared_host) else $error("shared data key wrong");

   property p_legacy_mode_private;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && guest_enc_active && acc_kind == gmes_pkg::GMES_ACC_DATA
         && !guest_long_or_ext_paging) |=> res_guest_key;
   endproperty
   a_legacy_mode_private: assert property (p_legacy_mode_private)
      else $error("legacy mode data not private");

   property p_no_guest_key_outside;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && !guest_encryption_enable) |=> !res_guest_key;
   endproperty
   a_no_guest_key_outside: assert property (p_no_guest_key_outside)
      else $error("guest key without guest encryption");

   property p_strip;
      @(posedge clock) disable iff (rst)
      (acc_valid && !core_stall && guest_mode && guest_long_or_ext_paging && cbit_is_addr)
         |=> (res_nested_gpa[cap_cbit_pos] == 1'b0);
   endproperty
   a_strip: assert property (p_strip) else $error("select bit not cleared");

   property p_flush_stall;
      @(posedge clock) disable iff (rst)
      (fl_r == gmes_pkg::GMES_FL_IDLE && reg_wr && reg_addr == `GMES_FLUSH_REG_ADDR)
         |=> (core_stall && xlate_req && xlate_vaddr[`GMES_VA_LO-1:0] == 12'h000);
   endproperty
   a_flush_stall: assert property (p_flush_stall) else $error("flush did not start");

   property p_flush_key;
      @(posedge clock) disable iff (rst)
      $rose(cache_flush_req) |-> (cache_flush_private_only && $stable(cache_flush_key));
   endproperty
   a_flush_key: assert property (p_flush_key) else $error("flush key changed");
endmodule : gmes_select

// File: verification/gmes_cache_model.sv
// Purpose: Behavioural model of host translation and the cache flush engine.
// Assumes: The block issues one flush request at a time.
// Notes: Slow mode answers after seven cycles, prompt mode after one.
`timescale 1ns/10ps
module gmes_cache_model #(
   parameter logic [63:0] PHYS_OFS = 64'h0000000100000000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Answer speed
   input wire logic slow,
   // Requests from the block
   input wire logic xlate_req,
   input wire logic [63:0] xlate_vaddr,
   input wire logic cache_flush_req,
   // Answers
   output logic xlate_done,
   output logic [63:0] xlate_phys,
   output logic cache_done
);
   logic [3:0] wait_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_r <= 4'h0;
         xlate_done <= 1'b0;
         cache_done <= 1'b0;
         xlate_phys <= 64'h0;
      end else begin
         xlate_done <= 1'b0;
         cache_done <= 1'b0;
         // The result is only valid with the done pulse, so it toggles otherwise.
         xlate_phys <= ~xlate_phys;
         if ((xlate_req || cache_flush_req) && !xlate_done && !cache_done) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= (slow ? 4'h6 : 4'h0)) begin
               wait_r <= 4'h0;
               xlate_done <= xlate_req;
               cache_done <= cache_flush_req;
               xlate_phys <= {xlate_vaddr[63:12], 12'h000} + PHYS_OFS;
            end
         end
      end
   end
endmodule : gmes_cache_model

// File: verification/gmes_select_tb.sv
// Purpose: Self-checking bench for the encryption select block.
// Assumes: The partner model stands for translation and caches.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`include "gmes_params.svh"
module gmes_select_tb;
   localparam logic [63:0] OFS = 64'h0000000100000000;
   localparam logic [63:0] SPA = 64'h0000001234500000;
   localparam logic [63:0] GPA_LO = 64'h0000000000abc321;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic [8:0] m = 9'h000;
   logic acc_valid = 1'b0;
   logic cbit_addr = 1'b1;
   logic reg_wr = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [63:0] reg_wdata = 64'h0;
   logic res_valid, res_encrypt, res_guest_key, xlate_req, xlate_done, cache_flush_req;
   logic cache_done, cache_flush_private_only, core_stall;
   logic [3:0] res_key_index, cache_flush_key;
   logic [63:0] res_nested_gpa, res_spa, xlate_vaddr, xlate_phys, cache_flush_addr;
   logic [5:0] cap_cbit_pos;
   logic [31:0] cap_features;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   always #25 clock = ~clock;
   gmes_select dut_u (
      .clock, .rst,
      .global_encryption_enable(m[8]),
      .guest_mode(m[7]),
      .guest_encryption_enable(m[6]),
      .guest_long_or_ext_paging(m[5]),
      .cbit_is_addr(cbit_addr),
      .acc_valid,
      .acc_kind(gmes_pkg::gmes_access_t'(m[1:0])),
      .acc_addr({16'h0000, m[3], 47'h00000000abc321}),
      .host_table_cbit(m[4]),
      .guest_table_cbit(m[3]),
      .nested_table_cbit(m[2]),
      .guest_key_index(4'h5),
      .nested_spa(SPA),
      .reg_wr, .reg_addr, .reg_wdata, .xlate_done, .xlate_phys, .cache_done,
      .res_valid, .res_encrypt, .res_guest_key, .res_key_index, .res_nested_gpa, .res_spa,
      .xlate_req, .xlate_vaddr, .cache_flush_req, .cache_flush_addr, .cache_flush_key,
      .cache_flush_private_only, .core_stall, .cap_cbit_pos, .cap_features
   );
   gmes_cache_model #(.PHYS_OFS(OFS)) model_u (
      .clock, .rst, .slow, .xlate_req, .xlate_vaddr, .cache_flush_req,
      .xlate_done, .xlate_phys, .cache_done
   );
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   always @(posedge clock) begin
      cyc++;
      if (cyc == 1000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic chk(input logic c, input string s);
      n_compared++;
      if (c !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s", $time, s);
      end
   endtask : chk
   // Mode bits are {global, guest, guest enc, long paging, host, guest, nested, kind}.
   task automatic acc(input logic [8:0] v, input logic [1:0] e);
      logic [63:0] sel;
      sel = {16'h0000, v[3], 47'h0};
      @(posedge clock);
      #1 m = v;
      acc_valid = 1'b1;
      @(posedge clock);
      #1 acc_valid = 1'b0;
      chk(res_valid === 1'b1, "no result");
      chk(res_encrypt === e[1], "encryption");
      if (e[1]) chk(res_guest_key === e[0], "key choice");
      if (e[1]) chk(res_key_index === (e[0] ? 4'h5 : 4'h0), "key index");
      if (v[8:5] == 4'b1111 && v[1:0] == 2'b11) begin
         chk(res_nested_gpa === (GPA_LO | ({64{!cbit_addr}} & sel)), "guest address");
         chk(res_spa === (SPA | ({64{cbit_addr}} & sel)), "final address");
      end
   endtask : acc
   task automatic wr(input logic [31:0] a, input logic [63:0] d);
      @(posedge clock);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1 reg_wr = 1'b0;
   endtask : wr
   task automatic fl(input logic [63:0] d);
      int i;
      wr(`GMES_FLUSH_REG_ADDR, d);
      chk(xlate_req === 1'b1 && core_stall === 1'b1, "flush start");
      chk(xlate_vaddr === {d[63:12], 12'h000}, "flush page");
      if (slow) begin
         @(posedge clock);
         #1 acc_valid = 1'b1;
         @(posedge clock);
         #1 acc_valid = 1'b0;
         chk(res_valid === 1'b0, "access during flush");
         wr(`GMES_FLUSH_REG_ADDR, ~d);
      end
      i = 0;
      while (cache_flush_req !== 1'b1 && i < 40) begin
         @(posedge clock);
         #1 i++;
      end
      chk(cache_flush_req === 1'b1, "no cache flush");
      chk(cache_flush_addr === {d[63:12], 12'h000} + OFS, "flush target");
      chk(cache_flush_key === d[3:0], "flush key");
      chk(cache_flush_private_only === 1'b1, "private only");
      while (core_stall !== 1'b0 && i < 80) begin
         @(posedge clock);
         #1 i++;
      end
      @(posedge clock);
      #1 chk(core_stall === 1'b0 && xlate_req === 1'b0, "flush end");
      chk(cache_flush_req === 1'b0, "flush request held");
   endtask : fl
   initial begin
      repeat (12) @(posedge clock);
      #1 rst = 1'b0;
      acc(9'b0_1_1_1_1_1_1_00, 2'b00);
      acc(9'b1_0_0_1_1_0_0_11, 2'b10);
      acc(9'b1_0_0_1_0_1_1_11, 2'b00);
      acc(9'b1_1_0_1_0_1_1_11, 2'b10);
      acc(9'b1_1_0_1_1_1_0_11, 2'b00);
      acc(9'b1_0_1_1_1_1_1_11, 2'b10);
      acc(9'b1_1_1_1_0_0_0_00, 2'b11);
      acc(9'b1_1_1_1_0_0_1_01, 2'b11);
      acc(9'b1_1_1_1_0_1_0_10, 2'b00);
      acc(9'b1_1_1_1_0_0_1_10, 2'b10);
      acc(9'b1_1_1_1_0_1_0_11, 2'b11);
      cbit_addr = 1'b0;
      acc(9'b1_1_1_1_0_1_0_11, 2'b11);
      cbit_addr = 1'b1;
      acc(9'b1_1_1_1_0_1_1_11, 2'b11);
      acc(9'b1_1_1_1_0_0_1_11, 2'b10);
      acc(9'b1_1_1_1_0_0_0_11, 2'b00);
      acc(9'b1_1_1_0_0_0_0_11, 2'b11);
      acc(9'b0_1_1_0_0_1_1_11, 2'b00);
      chk(cap_cbit_pos === 6'h2f, "select bit position");
      chk(cap_features[2] === 1'b1, "flush capability");
      wr(32'h00000010, 64'h00007f1234567ab9);
      chk(xlate_req === 1'b0 && core_stall === 1'b0, "stray flush");
      slow = 1'b1;
      fl(64'h00007f1234567ab9);
      slow = 1'b0;
      fl(64'h0000000000001ff3);
      acc(9'b1_1_1_1_0_1_0_11, 2'b11);
      results();
   end
endmodule : gmes_select_tb
